// ===== src/tbl_engine.sv
// Card-side block-link engine: block receive, classify, reply and timing.
`timescale 1ns/10ps

// How it works
// - Responses longer than IFSD go out as chained I-blocks, default 32.
// - An IFS request for 255 gets an R-block with error code 2.
// - After IFSD is set to 254, a fitting response is one unchained block.
// - The announced character waiting integer sits in TB3 low nibble, 0..5.
// - Successive sent characters stay closer together than CWT.
// - Reply starts later than BGT and sooner than BWT after last received.
// - The reply window is waived right after a waiting-time extension.
// - A command arriving 22 etu after our last block is received normally.
// - Slow processing triggers a waiting-time-extension request.
// - Every announced TCi character is zero, selecting LRC.
// - Every sent block carries zero node addresses.
// - A received block with a nonzero node address gets no reply.
// - All transmission control sits in the protocol control byte.
// - I, R and S blocks are all supported.
// - IFSC defaults to 32 and is announced in TA3.
// - An accepted IFS request is echoed, and the new IFSD then holds.
module tbl_engine
#(
  parameter int ETU_NS   = tbl_pkg::ETU_NS_DEF,
  parameter int BWT_ETU  = tbl_pkg::BWT_ETU_DEF,
  parameter int WTX_LEAD = tbl_pkg::WTX_LEAD_DEF
)
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  output logic            tx_valid,
  output logic [7:0]      tx_data,
  input  wire logic       tx_ready,
  output logic            cmd_valid,
  output logic [7:0]      cmd_data,
  output logic            cmd_last,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_data,
  input  wire logic       rsp_last,
  output logic            rsp_ready,
  input  wire logic [3:0] cwi_cfg,
  output logic [7:0]      tb3_char,
  output logic [7:0]      tc_char,
  output logic [7:0]      ta3_char,
  output logic [7:0]      ifsd_value,
  output logic            cwt_late,
  output logic            bwt_late
);
  localparam int          ETU_CYC   = (ETU_NS + tbl_pkg::CLK_NS - 1)
                                      / tbl_pkg::CLK_NS;
  localparam logic [15:0] ETU_LAST  = 16'(ETU_CYC - 1);
  localparam logic [15:0] BWT_CNT   = 16'(BWT_ETU);
  localparam logic [15:0] WTX_CNT   = 16'(BWT_ETU - WTX_LEAD);
  localparam logic [7:0]  IFSC      = tbl_pkg::IFS_DEF;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    tbl_pkg::tbl_state_t st;
    tbl_pkg::tbl_phase_t ph;
    logic [15:0]         div;
    logic [15:0]         since_rx;
    logic [15:0]         since_tx;
    logic [7:0]          nad;
    logic [7:0]          pcb;
    logic [7:0]          len;
    logic [7:0]          idx;
    logic [7:0]          lrc;
    logic                lrc_bad;
    logic [7:0]          ifsd;
    logic                own_ns;
    logic                peer_nr;
    logic                exempt;
    logic                wtx_wait;
    logic [8:0]          rsp_len;
    logic [8:0]          rsp_ptr;
    logic                rsp_done;
    logic [7:0]          tx_pcb;
    logic [7:0]          tx_len;
    logic                tx_mem;
    logic [7:0]          tx_one;
    logic [7:0]          tx_idx;
    logic [7:0]          tx_lrc;
    logic                cmd_valid;
    logic [7:0]          cmd_data;
    logic                cmd_last;
    logic                rsp_rdy;
    logic [7:0]          tb3;
    logic                cwt_late;
    logic                bwt_late;
  } tbl_eng_t;

  tbl_eng_t    r_reg;
  tbl_eng_t    r_next;
  logic [7:0]  rx_mem  [0:tbl_pkg::INF_MAX-1];
  logic [7:0]  rsp_mem [0:tbl_pkg::RSP_DEPTH-1];
  logic        etu_tick;
  logic        push_valid;
  logic [7:0]  push_data;
  logic        push_ready;
  logic [15:0] cwt_cnt;
  logic [8:0]  remain;
  logic [3:0]  cwi_ok;

  function automatic logic [7:0] r_block(input logic nr, input logic [3:0] c);
    r_block = tbl_pkg::PCB_R_BASE | {3'h0, nr, c};
  endfunction : r_block

  function automatic tbl_pkg::tbl_btype_t btype(input logic [7:0] pcb);
    if (!pcb[7])
      btype = tbl_pkg::BT_I;
    else if (!pcb[6])
      btype = tbl_pkg::BT_R;
    else
      btype = tbl_pkg::BT_S;
  endfunction : btype

  assign etu_tick = (r_reg.div == ETU_LAST);
  assign cwi_ok   = (cwi_cfg > tbl_pkg::CWI_MAX) ? tbl_pkg::CWI_MAX
                                                 : cwi_cfg;
  assign cwt_cnt  = tbl_pkg::CWT_BASE_ETU + (16'h0001 << cwi_ok);
  assign remain   = r_reg.rsp_len - r_reg.rsp_ptr;

  always_comb
  begin
    push_valid = (r_reg.st == tbl_pkg::ST_TX);
    case (r_reg.ph)
      tbl_pkg::PH_NAD: push_data = tbl_pkg::NAD_ZERO;
      tbl_pkg::PH_PCB: push_data = r_reg.tx_pcb;
      tbl_pkg::PH_LEN: push_data = r_reg.tx_len;
      tbl_pkg::PH_INF: push_data = r_reg.tx_mem
          ? rsp_mem[8'(r_reg.rsp_ptr + {1'b0, r_reg.tx_idx})] : r_reg.tx_one;
      default:         push_data = r_reg.tx_lrc;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    r_next           = r_reg;
    r_next.cmd_valid = 1'b0;
    r_next.cmd_last  = 1'b0;
    r_next.tb3       = {tbl_pkg::BWI_DEF, cwi_ok};
    r_next.div       = etu_tick ? 16'h0000 : 16'(r_reg.div + 16'h0001);
    if (etu_tick && r_reg.since_rx != 16'hFFFF)
      r_next.since_rx = 16'(r_reg.since_rx + 16'h0001);
    if (etu_tick && r_reg.since_tx != 16'hFFFF)
      r_next.since_tx = 16'(r_reg.since_tx + 16'h0001);
    if (rx_valid)
      r_next.since_rx = 16'h0000;

    case (r_reg.st)
      // Any idle moment listens, so a command 22 etu after a reply is taken.
      tbl_pkg::ST_NAD:
        if (rx_valid)
        begin
          r_next.nad = rx_data;
          r_next.lrc = rx_data;
          r_next.st  = tbl_pkg::ST_PCB;
        end
      tbl_pkg::ST_PCB, tbl_pkg::ST_LEN, tbl_pkg::ST_INF, tbl_pkg::ST_EDC:
        if (rx_valid)
        begin
          r_next.lrc = r_reg.lrc ^ rx_data;
          r_next.idx = 8'(r_reg.idx + 8'h01);
          if (r_reg.st == tbl_pkg::ST_PCB)
          begin
            r_next.pcb = rx_data;
            r_next.st  = tbl_pkg::ST_LEN;
          end
          else if (r_reg.st == tbl_pkg::ST_LEN)
          begin
            r_next.len = rx_data;
            r_next.idx = 8'h00;
            r_next.st  = (rx_data == 8'h00) ? tbl_pkg::ST_EDC
                                            : tbl_pkg::ST_INF;
          end
          else if (r_reg.st == tbl_pkg::ST_INF)
          begin
            if (r_reg.idx == 8'(r_reg.len - 8'h01))
              r_next.st = tbl_pkg::ST_EDC;
          end
          else
          begin
            r_next.lrc_bad = ((r_reg.lrc ^ rx_data) != 8'h00);
            r_next.st      = tbl_pkg::ST_DECIDE;
          end
        end
        else if (r_reg.since_rx > cwt_cnt)
          r_next.st = r_reg.wtx_wait ? tbl_pkg::ST_WORK : tbl_pkg::ST_NAD;
      tbl_pkg::ST_DECIDE:
      begin
        r_next.st     = tbl_pkg::ST_GUARD;
        r_next.tx_mem = 1'b0;
        r_next.tx_len = 8'h00;
        r_next.idx    = 8'h00;
        if (r_reg.nad != tbl_pkg::NAD_ZERO)
          r_next.st = r_reg.wtx_wait ? tbl_pkg::ST_WORK : tbl_pkg::ST_NAD;
        else if (r_reg.lrc_bad)
          r_next.tx_pcb = r_block(r_reg.peer_nr, tbl_pkg::R_ERR_EDC);
        else
          case (btype(r_reg.pcb))
            tbl_pkg::BT_I:
              if (r_reg.len > IFSC)
                r_next.tx_pcb = r_block(r_reg.peer_nr, tbl_pkg::R_ERR_OTHER);
              else
              begin
                r_next.peer_nr = ~r_reg.pcb[tbl_pkg::PCB_NS_BIT];
                r_next.st      = tbl_pkg::ST_CMD;
              end
            tbl_pkg::BT_R:
              if (r_reg.rsp_ptr < r_reg.rsp_len)
                r_next.st = tbl_pkg::ST_WORK;
              else
                r_next.tx_pcb = r_block(r_reg.peer_nr, tbl_pkg::R_ERR_OTHER);
            default:
              if (r_reg.pcb == tbl_pkg::PCB_S_IFS)
              begin
                if (r_reg.len != 8'h01 || rx_mem[0] == tbl_pkg::IFS_BAD
                    || rx_mem[0] == 8'h00)
                  r_next.tx_pcb = r_block(r_reg.peer_nr,
                                          tbl_pkg::R_ERR_OTHER);
                else
                begin
                  r_next.ifsd   = rx_mem[0];
                  r_next.tx_pcb = r_reg.pcb | tbl_pkg::PCB_S_RSP;
                  r_next.tx_one = rx_mem[0];
                  r_next.tx_len = 8'h01;
                end
              end
              else if (r_reg.pcb == (tbl_pkg::PCB_S_WTX | tbl_pkg::PCB_S_RSP)
                       && r_reg.wtx_wait)
              begin
                r_next.exempt = 1'b1;
                r_next.st     = tbl_pkg::ST_WORK;
                r_next.rsp_rdy = 1'b1;
              end
              else if (r_reg.pcb == tbl_pkg::PCB_S_RESYNC
                       || r_reg.pcb == tbl_pkg::PCB_S_ABORT)
              begin
                r_next.tx_pcb  = r_reg.pcb | tbl_pkg::PCB_S_RSP;
                r_next.rsp_len = 9'h000;
                r_next.rsp_ptr = 9'h000;
                if (r_reg.pcb == tbl_pkg::PCB_S_RESYNC)
                begin
                  r_next.ifsd    = tbl_pkg::IFS_DEF;
                  r_next.own_ns  = 1'b0;
                  r_next.peer_nr = 1'b0;
                end
              end
              else
                r_next.tx_pcb = r_block(r_reg.peer_nr, tbl_pkg::R_ERR_OTHER);
          endcase
      end
      tbl_pkg::ST_CMD:
      begin
        r_next.cmd_valid = 1'b1;
        r_next.cmd_data  = rx_mem[r_reg.idx];
        r_next.idx       = 8'(r_reg.idx + 8'h01);
        if (r_reg.idx == 8'(r_reg.len - 8'h01) || r_reg.len == 8'h00)
        begin
          r_next.cmd_valid = (r_reg.len != 8'h00);
          r_next.cmd_last  = !r_reg.pcb[tbl_pkg::PCB_M_BIT];
          r_next.rsp_len   = 9'h000;
          r_next.rsp_ptr   = 9'h000;
          r_next.rsp_done  = 1'b0;
          r_next.rsp_rdy   = !r_reg.pcb[tbl_pkg::PCB_M_BIT];
          r_next.st        = tbl_pkg::ST_WORK;
          if (r_reg.pcb[tbl_pkg::PCB_M_BIT])
          begin
            r_next.tx_pcb = r_block(~r_reg.pcb[tbl_pkg::PCB_NS_BIT], 4'h0);
            r_next.st     = tbl_pkg::ST_GUARD;
          end
        end
      end
      tbl_pkg::ST_WORK:
      begin
        r_next.wtx_wait = 1'b0;
        if (r_reg.rsp_rdy && rsp_valid)
        begin
          r_next.rsp_len = 9'(r_reg.rsp_len + 9'h001);
          r_next.rsp_done = rsp_last;
          r_next.rsp_rdy  = !rsp_last
                            && (r_reg.rsp_len != 9'(tbl_pkg::RSP_DEPTH - 1));
          if (r_reg.rsp_len == 9'(tbl_pkg::RSP_DEPTH - 1))
            r_next.rsp_done = 1'b1;
        end
        else if (r_reg.rsp_done)
        begin
          r_next.rsp_rdy = 1'b0;
          r_next.tx_mem  = 1'b1;
          r_next.tx_idx  = 8'h00;
          r_next.tx_len  = (remain > {1'b0, r_reg.ifsd}) ? r_reg.ifsd
                                                         : remain[7:0];
          r_next.tx_pcb  = {1'b0, r_reg.own_ns,
                            (remain > {1'b0, r_reg.ifsd}), 5'h00};
          r_next.st      = tbl_pkg::ST_GUARD;
        end
        else if (r_reg.since_rx >= WTX_CNT)
        begin
          r_next.tx_pcb   = tbl_pkg::PCB_S_WTX;
          r_next.tx_one   = tbl_pkg::WTX_MULT;
          r_next.tx_len   = 8'h01;
          r_next.tx_mem   = 1'b0;
          r_next.wtx_wait = 1'b1;
          r_next.rsp_rdy  = 1'b0;
          r_next.st       = tbl_pkg::ST_GUARD;
        end
      end
      tbl_pkg::ST_GUARD:
        if (r_reg.exempt || r_reg.since_rx > tbl_pkg::BGT_ETU)
        begin
          r_next.bwt_late = !r_reg.exempt && (r_reg.since_rx >= BWT_CNT);
          r_next.ph       = tbl_pkg::PH_NAD;
          r_next.tx_lrc   = 8'h00;
          r_next.since_tx = 16'h0000;
          r_next.st       = tbl_pkg::ST_TX;
        end
      tbl_pkg::ST_TX:
      begin
        if (r_reg.since_tx >= cwt_cnt)
          r_next.cwt_late = 1'b1;
        // Bytes come from local storage, so pushes wait only on room in the buffer.
        if (push_ready)
        begin
          r_next.since_tx = 16'h0000;
          r_next.tx_lrc   = r_reg.tx_lrc ^ push_data;
          case (r_reg.ph)
            tbl_pkg::PH_NAD: r_next.ph = tbl_pkg::PH_PCB;
            tbl_pkg::PH_PCB: r_next.ph = tbl_pkg::PH_LEN;
            tbl_pkg::PH_LEN: r_next.ph = (r_reg.tx_len == 8'h00)
                                         ? tbl_pkg::PH_EDC : tbl_pkg::PH_INF;
            tbl_pkg::PH_INF:
            begin
              r_next.tx_idx = 8'(r_reg.tx_idx + 8'h01);
              if (r_reg.tx_idx == 8'(r_reg.tx_len - 8'h01))
                r_next.ph = tbl_pkg::PH_EDC;
            end
            default:
            begin
              r_next.exempt = 1'b0;
              r_next.st     = tbl_pkg::ST_NAD;
              if (r_reg.tx_mem)
              begin
                r_next.own_ns  = ~r_reg.own_ns;
                r_next.rsp_ptr = 9'(r_reg.rsp_ptr + {1'b0, r_reg.tx_len});
                r_next.rsp_done = 1'b0;
                if (!r_reg.tx_pcb[tbl_pkg::PCB_M_BIT])
                begin
                  r_next.rsp_len  = 9'h000;
                  r_next.rsp_ptr  = 9'h000;
                end
              end
            end
          endcase
        end
      end
      default: r_next.st = tbl_pkg::ST_NAD;
    endcase
    // After a chained block the rest is released by the terminal's R-block.
    if (r_reg.st == tbl_pkg::ST_DECIDE && btype(r_reg.pcb) == tbl_pkg::BT_R
        && r_reg.nad == tbl_pkg::NAD_ZERO && !r_reg.lrc_bad
        && r_reg.rsp_ptr < r_reg.rsp_len)
      r_next.rsp_done = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r_reg      <= '0;
      r_reg.ifsd <= tbl_pkg::IFS_DEF;
    end
    else
      r_reg <= r_next;
  end

  // Storage arrays carry no reset; every read is guarded by a length.
  always_ff @(posedge ref_clk)
  begin
    if (r_reg.st == tbl_pkg::ST_INF && rx_valid)
      rx_mem[r_reg.idx] <= rx_data;
    if (r_reg.st == tbl_pkg::ST_WORK && r_reg.rsp_rdy && rsp_valid)
      rsp_mem[r_reg.rsp_len[7:0]] <= rsp_data;
  end

  // ****************************************************************
  // Transmit buffer and outputs
  // ****************************************************************
  logic buf_in_ready;

  tbl_buf2 u_buf
  (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (push_valid),
    .in_data   (push_data),
    .in_ready  (buf_in_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  assign push_ready = push_valid && buf_in_ready;
  assign cmd_valid  = r_reg.cmd_valid;
  assign cmd_data   = r_reg.cmd_data;
  assign cmd_last   = r_reg.cmd_last;
  assign rsp_ready  = r_reg.rsp_rdy;
  assign tb3_char   = r_reg.tb3;
  assign tc_char    = tbl_pkg::TC_LRC;
  assign ta3_char   = IFSC;
  assign ifsd_value = r_reg.ifsd;
  assign cwt_late   = r_reg.cwt_late;
  assign bwt_late   = r_reg.bwt_late;
endmodule : tbl_engine

// ===== src/tbl_pkg_buf.sv
// Shared constants of the block-link engine and its two-entry transmit buffer.
`timescale 1ns/10ps

package tbl_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_NS       = 25;
  localparam int          ETU_NS_DEF   = 9300;
  localparam logic [15:0] BGT_ETU      = 16'd22;
  localparam logic [15:0] CWT_BASE_ETU = 16'd11;
  localparam logic [3:0]  CWI_MAX      = 4'h5;
  localparam logic [3:0]  BWI_DEF      = 4'h4;
  localparam int          BWT_ETU_DEF  = 15371;
  localparam int          WTX_LEAD_DEF = 1000;
  // ****************************************************************
  // Block layout and codes
  // ****************************************************************
  localparam logic [7:0]  IFS_DEF      = 8'h20;
  localparam logic [7:0]  IFS_BAD      = 8'hFF;
  localparam logic [7:0]  NAD_ZERO     = 8'h00;
  localparam logic [7:0]  TC_LRC       = 8'h00;
  localparam logic [7:0]  PCB_R_BASE   = 8'h80;
  localparam logic [7:0]  PCB_S_RESYNC = 8'hC0;
  localparam logic [7:0]  PCB_S_IFS    = 8'hC1;
  localparam logic [7:0]  PCB_S_ABORT  = 8'hC2;
  localparam logic [7:0]  PCB_S_WTX    = 8'hC3;
  localparam logic [7:0]  PCB_S_RSP    = 8'h20;
  localparam logic [7:0]  WTX_MULT     = 8'h01;
  localparam logic [3:0]  R_ERR_EDC    = 4'h1;
  localparam logic [3:0]  R_ERR_OTHER  = 4'h2;
  localparam int          PCB_NS_BIT   = 6;
  localparam int          PCB_M_BIT    = 5;
  localparam int          PCB_NR_BIT   = 4;
  localparam int          RSP_DEPTH    = 256;
  localparam int          INF_MAX      = 254;

  typedef enum logic [1:0] {BT_I, BT_R, BT_S} tbl_btype_t;

  typedef enum logic [3:0] {
    ST_NAD, ST_PCB, ST_LEN, ST_INF, ST_EDC, ST_DECIDE,
    ST_CMD, ST_WORK, ST_GUARD, ST_TX
  } tbl_state_t;

  typedef enum logic [2:0] {
    PH_NAD, PH_PCB, PH_LEN, PH_INF, PH_EDC
  } tbl_phase_t;
endpackage : tbl_pkg

module tbl_buf2
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready,
  output logic            out_valid,
  output logic [7:0]      out_data,
  input  wire logic       out_ready
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [7:0] head;
    logic [7:0] tail;
  } tbl_buf_t;

  tbl_buf_t r_reg;
  tbl_buf_t r_next;
  logic     push;
  logic     pop;

  assign in_ready  = (r_reg.cnt != 2'h2);
  assign out_valid = (r_reg.cnt != 2'h0);
  assign out_data  = r_reg.head;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Head holds the oldest word so the output comes straight from a flop.
  always_comb
  begin
    r_next = r_reg;
    if (pop && (r_reg.cnt == 2'h2))
      r_next.head = r_reg.tail;
    if (push && ((r_reg.cnt == 2'h0) || (pop && r_reg.cnt == 2'h1)))
      r_next.head = in_data;
    else if (push)
      r_next.tail = in_data;
    r_next.cnt = 2'(r_reg.cnt + {1'b0, push} - {1'b0, pop});
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end
endmodule : tbl_buf2

// ===== bench/tbl_term.sv
// Terminal model: frames blocks onto the link and collects the card's replies.
`timescale 1ns/10ps

module tbl_term
(
  input  wire logic       ref_clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       slow;

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h5A;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  // A stalling terminal toggles ready, so the card's buffer must hold words.
  always @(negedge ref_clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;

  always @(posedge ref_clk)
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);

  // Sends the prologue and field, then the LRC; idle data shows the inverse.
  task automatic send(input logic [7:0] b[$]);
    logic [7:0] lrc;
    lrc = 8'h00;
    foreach (b[i])
      lrc = lrc ^ b[i];
    b.push_back(lrc);
    foreach (b[i])
    begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data  = b[i];
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_data  = ~b[i];
      repeat (6) @(negedge ref_clk);
    end
  endtask : send
endmodule : tbl_term

// ===== bench/tbl_engine_sva.sv
// Port checks for the block-link engine.
`timescale 1ns/10ps

module tbl_engine_sva
#(
  parameter int ETU_NS  = 100,
  parameter int BWT_ETU = 200
)
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       rx_valid,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_ready,
  input wire logic [3:0] cwi_cfg,
  input wire logic [7:0] tb3_char,
  input wire logic [7:0] tc_char,
  input wire logic [7:0] ifsd_value,
  input wire logic       cwt_late
);
  localparam int          ETU_CYC = (ETU_NS + 24) / 25;
  localparam logic [15:0] GUARD   = 16'(22 * ETU_CYC);
  localparam logic [15:0] BWTC    = 16'(BWT_ETU * ETU_CYC);
  logic [15:0] since_rx_reg;
  logic [8:0]  pos_reg;
  logic [7:0]  len_reg;
  logic [7:0]  lrc_reg;
  logic [3:0]  cwi_cl;
  logic        last_c;

  assign cwi_cl = (cwi_cfg > 4'h5) ? 4'h5 : cwi_cfg;
  assign last_c = pos_reg > 9'h002 && pos_reg == {1'b0, len_reg} + 9'h003;

  // Tracks the byte position inside each sent block to find its fields.
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      since_rx_reg <= 16'h0000;
      pos_reg      <= 9'h000;
      len_reg      <= 8'h00;
      lrc_reg      <= 8'h00;
    end
    else
    begin
      if (rx_valid)
        since_rx_reg <= 16'h0000;
      else if (since_rx_reg != 16'hFFFF)
        since_rx_reg <= since_rx_reg + 16'h0001;
      if (tx_valid && tx_ready)
      begin
        lrc_reg <= (pos_reg == 9'h000) ? tx_data : lrc_reg ^ tx_data;
        if (pos_reg == 9'h002)
          len_reg <= tx_data;
        pos_reg <= last_c ? 9'h000 : pos_reg + 9'h001;
      end
    end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_guard_time: assert property (
    $rose(tx_valid) |-> since_rx_reg >= GUARD)
    else $error("reply started inside guard time");
  a_reply_bwt: assert property (
    $rose(tx_valid) |-> since_rx_reg < BWTC)
    else $error("reply started after waiting time");
  a_nad_zero: assert property (
    tx_valid && pos_reg == 9'h000 |-> tx_data == 8'h00)
    else $error("sent node address not zero");
  a_len_ifsd: assert property (
    tx_valid && pos_reg == 9'h002 |-> tx_data <= ifsd_value)
    else $error("sent field longer than ifsd");
  a_lrc_ok: assert property (
    tx_valid && last_c |-> tx_data == lrc_reg)
    else $error("sent check byte wrong");
  a_tc_zero: assert property (
    tc_char == 8'h00)
    else $error("tc character not zero");
  a_tb3_cwi: assert property (
    $past(rst_n) && $stable(cwi_cfg) |-> tb3_char == {4'h4, cwi_cl})
    else $error("tb3 waiting integer wrong");
  a_tx_stands: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx word dropped under stall");
  a_cwt_flag: assert property (
    !cwt_late)
    else $error("character gap reached cwt");

  c_reply: cover property ($rose(tx_valid));
  c_stall: cover property (tx_valid && !tx_ready);
  c_wide: cover property (ifsd_value == 8'hFE);
endmodule : tbl_engine_sva

bind tbl_engine tbl_engine_sva #(
  .ETU_NS (ETU_NS),
  .BWT_ETU(BWT_ETU)
) u_tbl_engine_sva (
  .ref_clk   (ref_clk),
  .rst_n     (rst_n),
  .rx_valid  (rx_valid),
  .tx_valid  (tx_valid),
  .tx_data   (tx_data),
  .tx_ready  (tx_ready),
  .cwi_cfg   (cwi_cfg),
  .tb3_char  (tb3_char),
  .tc_char   (tc_char),
  .ifsd_value(ifsd_value),
  .cwt_late  (cwt_late)
);

// ===== bench/tbl_engine_tb.sv
// Self-checking bench for the card-side block-link engine.
`timescale 1ns/10ps

module tbl_engine_tb;
  logic       ref_clk;
  logic       rst_n;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;
  logic       cmd_valid;
  logic       rsp_valid;
  logic [7:0] rsp_data;
  logic       rsp_last;
  logic       rsp_ready;
  logic [3:0] cwi_cfg;
  logic [7:0] tb3_char;
  logic [7:0] tc_char;
  logic [7:0] ta3_char;
  logic [7:0] ifsd_value;
  logic       bwt_late;
  int         n_mismatch;
  int         checked;
  int         n_cmd;
  int         cyc;

  // Short etu and waiting time keep the run brief.
  tbl_engine #(.ETU_NS(100), .BWT_ETU(200), .WTX_LEAD(100)) u_tbl_engine (
    .ref_clk(ref_clk), .rst_n(rst_n), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .cmd_valid(cmd_valid), .cmd_data(),
    .cmd_last(), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_last(rsp_last), .rsp_ready(rsp_ready), .cwi_cfg(cwi_cfg),
    .tb3_char(tb3_char), .tc_char(tc_char), .ta3_char(ta3_char),
    .ifsd_value(ifsd_value), .cwt_late(), .bwt_late(bwt_late));

  tbl_term u_tbl_term (
    .ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  always #12.5 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (cmd_valid === 1'b1)
      n_cmd++;

  task automatic chk(input string what, input logic [7:0] e, g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk

  task automatic wait_n(input int n);
    int k;
    k = 0;
    while (u_tbl_term.got.size() < n && k < 3000)
    begin
      @(negedge ref_clk);
      k++;
    end
    repeat (2) @(negedge ref_clk);
    chk("size", 8'(n), 8'(u_tbl_term.got.size()));
  endtask : wait_n

  task automatic expect_q(input logic [7:0] e[$]);
    wait_n(e.size());
    foreach (e[i])
      chk("byte", e[i], u_tbl_term.got[i]);
    u_tbl_term.got.delete();
  endtask : expect_q

  // Each word is held until the edge that finds ready high.
  task automatic give_rsp(input int n);
    while (rsp_ready !== 1'b1)
      @(negedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      rsp_valid = 1'b1;
      rsp_data  = 8'(i);
      rsp_last  = (i == n - 1);
      while (rsp_ready !== 1'b1)
        @(negedge ref_clk);
      @(negedge ref_clk);
    end
    rsp_valid = 1'b0;
    rsp_last  = 1'b0;
  endtask : give_rsp

  task automatic t_atr;
    chk("tb3", 8'h45, tb3_char);
    chk("tc", 8'h00, tc_char);
    chk("ta3", 8'h20, ta3_char);
    cwi_cfg = 4'h3;
    repeat (2) @(negedge ref_clk);
    chk("tb3", 8'h43, tb3_char);
    $display("test atr done");
  endtask : t_atr

  task automatic t_ifs;
    u_tbl_term.send('{8'h00, 8'hC1, 8'h01, 8'hFF});
    expect_q('{8'h00, 8'h82, 8'h00, 8'h82});
    chk("ifsd", 8'h20, ifsd_value);
    u_tbl_term.send('{8'h00, 8'hC1, 8'h01, 8'hFE});
    expect_q('{8'h00, 8'hE1, 8'h01, 8'hFE, 8'h1E});
    chk("ifsd", 8'hFE, ifsd_value);
    u_tbl_term.slow = 1'b1;
    n_cmd = 0;
    u_tbl_term.send('{8'h00, 8'h00, 8'h02, 8'hA0, 8'hB0});
    give_rsp(40);
    wait_n(44);
    chk("pcb", 8'h00, u_tbl_term.got[1]);
    chk("cmds", 8'h02, 8'(n_cmd));
    chk("bwt", 8'h00, 8'(bwt_late));
    u_tbl_term.got.delete();
    u_tbl_term.slow = 1'b0;
    $display("test ifs done");
  endtask : t_ifs

  task automatic t_chain;
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("ifsd", 8'h20, ifsd_value);
    u_tbl_term.send('{8'h00, 8'h00, 8'h01, 8'hC4});
    give_rsp(40);
    wait_n(36);
    chk("pcb", 8'h20, u_tbl_term.got[1]);
    chk("len", 8'h20, u_tbl_term.got[2]);
    u_tbl_term.got.delete();
    // The acknowledgement arrives 22 etu after the card's last character.
    repeat (88) @(negedge ref_clk);
    u_tbl_term.send('{8'h00, 8'h90, 8'h00});
    wait_n(12);
    chk("pcb", 8'h40, u_tbl_term.got[1]);
    chk("len", 8'h08, u_tbl_term.got[2]);
    chk("inf", 8'h20, u_tbl_term.got[3]);
    u_tbl_term.got.delete();
    $display("test chain done");
  endtask : t_chain

  task automatic t_nad;
    logic [7:0] nads[3];
    nads = '{8'h01, 8'h10, 8'h11};
    n_cmd = 0;
    foreach (nads[i])
    begin
      u_tbl_term.send('{nads[i], 8'h00, 8'h01, 8'hC4});
      repeat (400) @(negedge ref_clk);
      chk("quiet", 8'h00, 8'(u_tbl_term.got.size()));
    end
    chk("cmds", 8'h00, 8'(n_cmd));
    $display("test nad done");
  endtask : t_nad

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // A hang is cut short well past the few thousand cycles the tests need.
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end

  initial
  begin
    ref_clk    = 1'b0;
    rst_n      = 1'b0;
    rsp_valid  = 1'b0;
    rsp_data   = 8'h00;
    rsp_last   = 1'b0;
    cwi_cfg    = 4'h9;
    n_mismatch = 0;
    checked    = 0;
    n_cmd      = 0;
    cyc        = 0;
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("ifsd", 8'h20, ifsd_value);
    t_atr;
    t_ifs;
    t_chain;
    t_nad;
    give_verdict;
  end
endmodule : tbl_engine_tb
